// ==== verilog/dusc_regs.svh ====
`ifndef DUSC_REGS_SVH
`define DUSC_REGS_SVH
`define DUSC_OFF_CTRL0 8'h00
`define DUSC_OFF_CTRL1 8'h01
`define DUSC_OFF_PWR 8'h02
`define DUSC_OFF_TXD0 8'h03
`define DUSC_OFF_RXD0 8'h04
`define DUSC_OFF_TXD1 8'h05
`define DUSC_OFF_RXD1 8'h06
`define DUSC_OFF_DIV0 8'h07
`define DUSC_OFF_DIV1 8'h08
`define DUSC_OFF_ISTAT 8'h09
`define DUSC_OFF_IMASK 8'h0A
`define DUSC_OFF_LSTAT 8'h0B
`define DUSC_BIT_MPROC 5
`define DUSC_BIT_RXEN 4
`define DUSC_BIT_NTX 3
`define DUSC_BIT_NRX 2
`define DUSC_BIT_TXDONE 1
`define DUSC_BIT_RXDONE 0
`define DUSC_BIT_P1SEL 7
`define DUSC_BIT_DOUBLE 7
`define DUSC_CTRL1_WMASK 8'hBF
`define DUSC_CTRL_RST 8'h00
`define DUSC_DIV_RST 8'h00
`define DUSC_FIXED_DIV 16'h0040
`define DUSC_VAR_UNIT 16'h0010
`endif

// ==== verilog/dusc_pkg.sv ====
package dusc_pkg;
  typedef enum logic [1:0] {
    DUSC_P0_NONE = 2'b00,
    DUSC_P0_8BIT = 2'b01,
    DUSC_P0_9FIX = 2'b10,
    DUSC_P0_9VAR = 2'b11
  } dusc_p0_mode_t;
  typedef enum logic {
    DUSC_TX_IDLE = 1'b0,
    DUSC_TX_SEND = 1'b1
  } dusc_tx_state_t;
  typedef enum logic [1:0] {
    DUSC_RX_IDLE = 2'b00,
    DUSC_RX_START = 2'b01,
    DUSC_RX_DATA = 2'b10,
    DUSC_RX_STOP = 2'b11
  } dusc_rx_state_t;
endpackage

// ==== verilog/dusc_port_if.sv ====
`timescale 1ns/1ps
interface dusc_port_if;
  logic active;
  logic nine_bit;
  logic mproc;
  logic rx_en;
  logic tx_start;
  logic tx_ninth;
  logic [7:0] tx_data;
  logic [15:0] bit_period;
  logic tx_busy;
  logic tx_done;
  logic rx_done;
  logic rx_ninth;
  logic [7:0] rx_data;
  logic txd;
  logic rxd;
  modport ctrl (output active, nine_bit, mproc, rx_en, tx_start, tx_ninth,
    tx_data, bit_period, rxd, input tx_busy, tx_done, rx_done, rx_ninth,
    rx_data, txd);
  modport eng (input active, nine_bit, mproc, rx_en, tx_start, tx_ninth,
    tx_data, bit_period, rxd, output tx_busy, tx_done, rx_done, rx_ninth,
    rx_data, txd);
endinterface

// ==== verilog/dusc_uart_engine.sv ====
`timescale 1ns/1ps
module dusc_uart_engine
(
  input wire logic clk_sys,
  input wire logic rst,
  dusc_port_if.eng port
);
  import dusc_pkg::*;
  dusc_tx_state_t tx_state_reg;
  dusc_rx_state_t rx_state_reg;
  logic [15:0] tx_cnt_reg;
  logic [3:0] tx_bits_reg;
  logic [10:0] tx_sh_reg;
  logic txd_reg;
  logic tx_done_reg;
  logic [15:0] rx_cnt_reg;
  logic [3:0] rx_bits_reg;
  logic [8:0] rx_sh_reg;
  logic [2:0] rxd_sync_reg;
  logic rxd_level_reg;
  logic rxd_prev_reg;
  logic rx_done_reg;
  logic rx_ninth_reg;
  logic [7:0] rx_data_reg;
  logic tx_tick;
  logic rx_tick;
  logic [3:0] tx_last;
  logic [3:0] rx_last;
  logic stop_ok;

  assign tx_tick = (tx_cnt_reg == port.bit_period - 16'h0001);
  assign rx_tick = (rx_cnt_reg == port.bit_period - 16'h0001);
  assign tx_last = port.nine_bit ? 4'hA : 4'h9;
  assign rx_last = port.nine_bit ? 4'h8 : 4'h7;
  assign port.tx_busy = (tx_state_reg == DUSC_TX_SEND);
  assign port.txd = txd_reg;
  assign port.tx_done = tx_done_reg;
  assign port.rx_done = rx_done_reg;
  assign port.rx_ninth = rx_ninth_reg;
  assign port.rx_data = rx_data_reg;
  // In 8-bit framing with the handshake feature on, bad stop bits drop
  assign stop_ok = port.nine_bit ? rx_sh_reg[8] : rxd_level_reg;

  // Frame is start, data LSB first, optional ninth bit, stop
  always_ff @(posedge clk_sys)
    if (rst || !port.active)
    begin
      tx_state_reg <= DUSC_TX_IDLE;
      tx_cnt_reg <= 16'h0000;
      tx_bits_reg <= 4'h0;
      tx_sh_reg <= 11'h7FF;
      tx_done_reg <= 1'b0;
    end
    else
    begin
      tx_done_reg <= 1'b0;
      case (tx_state_reg)
        DUSC_TX_IDLE:
          if (port.tx_start)
          begin
            tx_sh_reg <= {1'b1, port.nine_bit ? port.tx_ninth : 1'b1,
              port.tx_data, 1'b0};
            tx_cnt_reg <= 16'h0000;
            tx_bits_reg <= 4'h0;
            tx_state_reg <= DUSC_TX_SEND;
          end
        DUSC_TX_SEND:
          if (tx_tick)
          begin
            tx_cnt_reg <= 16'h0000;
            tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
            tx_bits_reg <= tx_bits_reg + 4'h1;
            if (tx_bits_reg == tx_last)
            begin
              tx_state_reg <= DUSC_TX_IDLE;
              tx_done_reg <= 1'b1;
            end
          end
          else
            tx_cnt_reg <= tx_cnt_reg + 16'h0001;
        default:
          tx_state_reg <= DUSC_TX_IDLE;
      endcase
    end

  always_ff @(posedge clk_sys)
    if (rst)
      txd_reg <= 1'b1;
    else
      // An abort to mode 00 must not leave a low bit standing on the line
      txd_reg <= (port.tx_busy && port.active) ? tx_sh_reg[0] : 1'b1;

  // Line input: third stage agrees with second before a change counts
  always_ff @(posedge clk_sys)
    if (rst)
    begin
      rxd_sync_reg <= 3'b111;
      rxd_level_reg <= 1'b1;
      rxd_prev_reg <= 1'b1;
    end
    else
    begin
      rxd_sync_reg <= {rxd_sync_reg[1:0], port.rxd};
      if (rxd_sync_reg[1] == rxd_sync_reg[2])
        rxd_level_reg <= rxd_sync_reg[2];
      rxd_prev_reg <= rxd_level_reg;
    end

  always_ff @(posedge clk_sys)
    if (rst || !port.active || !port.rx_en)
    begin
      rx_state_reg <= DUSC_RX_IDLE;
      rx_cnt_reg <= 16'h0000;
      rx_bits_reg <= 4'h0;
      rx_sh_reg <= 9'h000;
      rx_done_reg <= 1'b0;
      rx_ninth_reg <= 1'b0;
      rx_data_reg <= 8'h00;
    end
    else
    begin
      rx_done_reg <= 1'b0;
      case (rx_state_reg)
        DUSC_RX_IDLE:
          if (rxd_prev_reg && !rxd_level_reg)
          begin
            rx_cnt_reg <= 16'h0000;
            rx_state_reg <= DUSC_RX_START;
          end
        DUSC_RX_START:
          if (rx_cnt_reg == (port.bit_period >> 1))
          begin
            // Glitch shorter than half a bit is not a start
            rx_cnt_reg <= 16'h0000;
            rx_bits_reg <= 4'h0;
            rx_state_reg <= rxd_level_reg ? DUSC_RX_IDLE : DUSC_RX_DATA;
          end
          else
            rx_cnt_reg <= rx_cnt_reg + 16'h0001;
        DUSC_RX_DATA:
          if (rx_tick)
          begin
            rx_cnt_reg <= 16'h0000;
            rx_sh_reg <= {rxd_level_reg, rx_sh_reg[8:1]};
            rx_bits_reg <= rx_bits_reg + 4'h1;
            if (rx_bits_reg == rx_last)
              rx_state_reg <= DUSC_RX_STOP;
          end
          else
            rx_cnt_reg <= rx_cnt_reg + 16'h0001;
        DUSC_RX_STOP:
          if (rx_tick)
          begin
            rx_state_reg <= DUSC_RX_IDLE;
            if (!port.mproc || stop_ok)
            begin
              rx_done_reg <= 1'b1;
              rx_data_reg <= port.nine_bit ? rx_sh_reg[7:0] : rx_sh_reg[8:1];
              rx_ninth_reg <= stop_ok;
            end
          end
          else
            rx_cnt_reg <= rx_cnt_reg + 16'h0001;
        default:
          rx_state_reg <= DUSC_RX_IDLE;
      endcase
    end
endmodule

// ==== verilog/dusc_serial_ctrl.sv ====
`timescale 1ns/1ps
`include "dusc_regs.svh"
module dusc_serial_ctrl
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  output logic irq,
  output logic port0_txd,
  input wire logic port0_rxd,
  output logic port1_txd,
  input wire logic port1_rxd
);
  import dusc_pkg::*;

  logic [7:0] ctrl0_reg;
  logic [7:0] ctrl1_reg;
  logic double_reg;
  logic [7:0] div_reg [2];
  logic [7:0] txbuf_reg [2];
  logic [7:0] rxbuf_reg [2];
  logic [1:0] go_reg;
  logic [3:0] istat_reg;
  logic [3:0] imask_reg;
  logic [7:0] rdata_reg;
  logic [3:0] events;
  logic [15:0] var_period [2];
  logic wr_ctrl0;
  logic wr_ctrl1;
  dusc_p0_mode_t p0_mode;

  dusc_port_if pif [2] ();

  assign wr_ctrl0 = wr_en && (addr == `DUSC_OFF_CTRL0);
  assign wr_ctrl1 = wr_en && (addr == `DUSC_OFF_CTRL1);
  assign p0_mode = dusc_p0_mode_t'(ctrl0_reg[7:6]);

  // Port 0 control: mode, handshake feature, enables, ninth bits, flags
  assign pif[0].active = (p0_mode != DUSC_P0_NONE);
  assign pif[0].nine_bit = p0_mode[1];
  assign pif[0].mproc = ctrl0_reg[`DUSC_BIT_MPROC];
  assign pif[0].rx_en = ctrl0_reg[`DUSC_BIT_RXEN];
  assign pif[0].tx_ninth = ctrl0_reg[`DUSC_BIT_NTX];
  assign pif[0].rxd = port0_rxd;
  assign port0_txd = pif[0].txd;

  // Port 1 has no unavailable mode, so it is always active
  assign pif[1].active = 1'b1;
  assign pif[1].nine_bit = !ctrl1_reg[`DUSC_BIT_P1SEL];
  assign pif[1].mproc = ctrl1_reg[`DUSC_BIT_MPROC];
  assign pif[1].rx_en = ctrl1_reg[`DUSC_BIT_RXEN];
  assign pif[1].tx_ninth = ctrl1_reg[`DUSC_BIT_NTX];
  assign pif[1].rxd = port1_rxd;
  assign port1_txd = pif[1].txd;

  // Bit period in clocks; the variable rate is (divisor + 1) units
  always_comb
  begin
    var_period[0] = (16'(div_reg[0]) + 16'h0001) * `DUSC_VAR_UNIT;
    var_period[1] = (16'(div_reg[1]) + 16'h0001) * `DUSC_VAR_UNIT;
    if (p0_mode == DUSC_P0_9FIX)
      pif[0].bit_period = double_reg ? (`DUSC_FIXED_DIV >> 1)
        : `DUSC_FIXED_DIV;
    else
      pif[0].bit_period = double_reg ? (var_period[0] >> 1)
        : var_period[0];
    pif[1].bit_period = var_period[1];
  end

  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_port
      localparam logic [7:0] OFF_TX = (i == 0) ? `DUSC_OFF_TXD0
        : `DUSC_OFF_TXD1;
      localparam logic [7:0] OFF_DIV = (i == 0) ? `DUSC_OFF_DIV0
        : `DUSC_OFF_DIV1;

      // Assertion helper: clocks the transmitter has been busy this frame
      logic [15:0] busy_len_reg;
      always_ff @(posedge clk_sys)
        if (rst || !pif[i].tx_busy)
          busy_len_reg <= 16'h0000;
        else
          busy_len_reg <= busy_len_reg + 16'h0001;

      // A write while a frame is on the line is dropped, not queued
      always_ff @(posedge clk_sys)
        if (rst)
        begin
          go_reg[i] <= 1'b0;
          txbuf_reg[i] <= 8'h00;
        end
        else
        begin
          go_reg[i] <= wr_en && (addr == OFF_TX) && pif[i].active
            && !pif[i].tx_busy && !go_reg[i];
          if (wr_en && (addr == OFF_TX) && !pif[i].tx_busy && !go_reg[i])
            txbuf_reg[i] <= wdata;
        end

      always_ff @(posedge clk_sys)
        if (rst)
          div_reg[i] <= `DUSC_DIV_RST;
        else if (wr_en && (addr == OFF_DIV))
          div_reg[i] <= wdata;

      always_ff @(posedge clk_sys)
        if (rst)
          rxbuf_reg[i] <= 8'h00;
        else if (pif[i].rx_done)
          rxbuf_reg[i] <= pif[i].rx_data;

      assign pif[i].tx_start = go_reg[i];
      assign pif[i].tx_data = txbuf_reg[i];
      assign events[2 * i] = pif[i].tx_done;
      assign events[2 * i + 1] = pif[i].rx_done;

      dusc_uart_engine u_engine
      (
        .clk_sys(clk_sys),
        .rst(rst),
        .port(pif[i])
      );
    end
  endgenerate

  // Hardware sets are applied last so they win over a same-cycle clear
  always_ff @(posedge clk_sys)
    if (rst)
      ctrl0_reg <= `DUSC_CTRL_RST;
    else
    begin
      if (wr_ctrl0)
        ctrl0_reg <= wdata;
      if (pif[0].tx_done)
        ctrl0_reg[`DUSC_BIT_TXDONE] <= 1'b1;
      if (pif[0].rx_done)
      begin
        ctrl0_reg[`DUSC_BIT_RXDONE] <= 1'b1;
        ctrl0_reg[`DUSC_BIT_NRX] <= pif[0].rx_ninth;
      end
    end

  always_ff @(posedge clk_sys)
    if (rst)
      ctrl1_reg <= `DUSC_CTRL_RST;
    else
    begin
      if (wr_ctrl1)
        ctrl1_reg <= wdata & `DUSC_CTRL1_WMASK;
      if (pif[1].tx_done)
        ctrl1_reg[`DUSC_BIT_TXDONE] <= 1'b1;
      if (pif[1].rx_done)
      begin
        ctrl1_reg[`DUSC_BIT_RXDONE] <= 1'b1;
        ctrl1_reg[`DUSC_BIT_NRX] <= pif[1].rx_ninth;
      end
    end

  always_ff @(posedge clk_sys)
    if (rst)
      double_reg <= 1'b0;
    else if (wr_en && (addr == `DUSC_OFF_PWR))
      double_reg <= wdata[`DUSC_BIT_DOUBLE];

  always_ff @(posedge clk_sys)
    if (rst)
      imask_reg <= 4'h0;
    else if (wr_en && (addr == `DUSC_OFF_IMASK))
      imask_reg <= wdata[3:0];

  always_ff @(posedge clk_sys)
    if (rst)
      istat_reg <= 4'h0;
    else if (wr_en && (addr == `DUSC_OFF_ISTAT))
      istat_reg <= (istat_reg & ~wdata[3:0]) | events;
    else
      istat_reg <= istat_reg | events;

  assign irq = |(istat_reg & imask_reg);

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys)
    if (rst || !rd_en)
      rdata_reg <= 8'h00;
    else
      case (addr)
        `DUSC_OFF_CTRL0: rdata_reg <= ctrl0_reg;
        `DUSC_OFF_CTRL1: rdata_reg <= ctrl1_reg;
        `DUSC_OFF_PWR: rdata_reg <= {double_reg, 7'h00};
        `DUSC_OFF_TXD0: rdata_reg <= txbuf_reg[0];
        `DUSC_OFF_RXD0: rdata_reg <= rxbuf_reg[0];
        `DUSC_OFF_TXD1: rdata_reg <= txbuf_reg[1];
        `DUSC_OFF_RXD1: rdata_reg <= rxbuf_reg[1];
        `DUSC_OFF_DIV0: rdata_reg <= div_reg[0];
        `DUSC_OFF_DIV1: rdata_reg <= div_reg[1];
        `DUSC_OFF_ISTAT: rdata_reg <= {4'h0, istat_reg};
        `DUSC_OFF_IMASK: rdata_reg <= {4'h0, imask_reg};
        `DUSC_OFF_LSTAT: rdata_reg <= {6'h00, pif[1].tx_busy,
          pif[0].tx_busy};
        default: rdata_reg <= 8'h00;
      endcase

  assign rdata = rdata_reg;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_mode_none_idle: assert property (
    (p0_mode == DUSC_P0_NONE) |=> !pif[0].tx_busy && port0_txd)
    else $error("port 0 moved in unavailable mode");

  a_rx_enable_gate: assert property (
    !ctrl1_reg[`DUSC_BIT_RXEN] |=> !pif[1].rx_done)
    else $error("port 1 received while disabled");

  a_ninth_rx_stop: assert property (
    pif[0].rx_done && (p0_mode == DUSC_P0_8BIT)
      && !ctrl0_reg[`DUSC_BIT_MPROC]
    |=> ctrl0_reg[`DUSC_BIT_NRX] == $past(pif[0].rx_ninth))
    else $error("port 0 ninth receive bit not loaded");

  a_done_flag_sticky: assert property (
    ctrl1_reg[`DUSC_BIT_TXDONE] && !wr_ctrl1
    |=> ctrl1_reg[`DUSC_BIT_TXDONE])
    else $error("port 1 transmit flag cleared itself");

  a_done_flag_set: assert property (
    pif[0].tx_done |=> ctrl0_reg[`DUSC_BIT_TXDONE]
      && istat_reg[0])
    else $error("port 0 transmit flag not set");

  a_port1_framing: assert property (
    $fell(pif[1].tx_busy)
    |-> g_port[1].busy_len_reg
      == (ctrl1_reg[`DUSC_BIT_P1SEL] ? 16'h000A : 16'h000B)
      * pif[1].bit_period)
    else $error("port 1 framing does not follow selector");

  a_fixed_rate: assert property (
    (p0_mode == DUSC_P0_9FIX)
    |-> pif[0].bit_period == (double_reg ? 16'h0020 : 16'h0040))
    else $error("port 0 fixed rate wrong");

  a_start_bit_low: assert property (
    go_reg[0] && pif[0].active |=> ##1 !port0_txd [*8])
    else $error("port 0 start bit not low");

  a_idle_line_high: assert property (
    !pif[1].tx_busy && !$past(pif[1].tx_busy) |-> port1_txd)
    else $error("port 1 line not high while idle");

  a_irq_level: assert property (
    $rose(irq) |-> $past(|events) || $past(wr_en))
    else $error("interrupt rose without cause");

  a_p0_frame_len: assert property (
    $fell(pif[0].tx_busy) && pif[0].active
    |-> g_port[0].busy_len_reg
      == (p0_mode[1] ? 16'h000B : 16'h000A) * pif[0].bit_period)
    else $error("port 0 frame length wrong");

  a_p0_ninth_tx: assert property (
    go_reg[0] && pif[0].nine_bit
    |=> g_port[0].u_engine.tx_sh_reg[9] == $past(ctrl0_reg[`DUSC_BIT_NTX]))
    else $error("port 0 ninth transmit bit not loaded");

  a_p1_ninth_tx: assert property (
    go_reg[1] && pif[1].nine_bit
    |=> g_port[1].u_engine.tx_sh_reg[9] == $past(ctrl1_reg[`DUSC_BIT_NTX]))
    else $error("port 1 ninth transmit bit not loaded");

  a_rx_gate_p0: assert property (
    !ctrl0_reg[`DUSC_BIT_RXEN] |=> !pif[0].rx_done)
    else $error("port 0 received while disabled");

  a_p1_ninth_nine: assert property (
    pif[1].rx_done && pif[1].nine_bit && !ctrl1_reg[`DUSC_BIT_MPROC]
    |=> ctrl1_reg[`DUSC_BIT_NRX] == $past(g_port[1].u_engine.rx_sh_reg[8]))
    else $error("port 1 ninth receive bit not the ninth bit");

  a_p1_ninth_stop: assert property (
    pif[1].rx_done && ctrl1_reg[`DUSC_BIT_P1SEL]
      && !ctrl1_reg[`DUSC_BIT_MPROC]
    |=> ctrl1_reg[`DUSC_BIT_NRX] == $past(pif[1].rx_ninth))
    else $error("port 1 ninth receive bit not the stop bit");

  a_var_rate_double: assert property (
    (p0_mode == DUSC_P0_9VAR) && double_reg
    |-> pif[0].bit_period == ({8'h00, div_reg[0]} + 16'h0001) << 3)
    else $error("port 0 doubled variable rate wrong");

  a_p1_start_low: assert property (
    go_reg[1] |=> ##1 !port1_txd [*8])
    else $error("port 1 start bit not low");

  a_p0_idle_high: assert property (
    !pif[0].tx_busy && !$past(pif[0].tx_busy) |-> port0_txd)
    else $error("port 0 line not high while idle");

  a_p1_set_wins: assert property (
    pif[1].rx_done && wr_ctrl1 |=> ctrl1_reg[`DUSC_BIT_RXDONE])
    else $error("port 1 receive flag lost to a write");

  a_p1_status_rx: assert property (
    pif[1].rx_done |=> istat_reg[3])
    else $error("port 1 receive status not set");

  a_p0_status_rx: assert property (
    pif[0].rx_done |=> istat_reg[1] && ctrl0_reg[`DUSC_BIT_RXDONE])
    else $error("port 0 receive status not set");

  a_busy_write_drop: assert property (
    wr_en && (addr == `DUSC_OFF_TXD0) && pif[0].tx_busy |=> !go_reg[0])
    else $error("port 0 accepted data while busy");

  a_rdata_idle: assert property (
    !rd_en |=> rdata == 8'h00)
    else $error("read data outside its cycle");

  c_p0_fixed_frame: cover property (
    (p0_mode == DUSC_P0_9FIX) && pif[0].tx_done);
  c_p1_rx_frame: cover property (pif[1].rx_done && pif[1].nine_bit);
  c_set_beats_clear: cover property (wr_ctrl0 && pif[0].rx_done);
  c_p1_mode_b_rx: cover property (pif[1].rx_done && !pif[1].nine_bit);
  c_p0_doubled_tx: cover property (double_reg && pif[0].tx_done);
endmodule

// ==== tb/dusc_peer.sv ====
`timescale 1ns/1ps
module dusc_peer
(
  input wire logic clk_sys,
  input wire logic port0_txd,
  input wire logic port1_txd,
  output logic port0_rxd,
  output logic port1_rxd
);
  // Lines rest at the mark level between frames, as a pulled-up line would
  initial
  begin
    port0_rxd = 1'b1;
    port1_rxd = 1'b1;
  end

  task automatic send(input bit p, input logic [7:0] d, input logic ninth,
    input bit nine, input int per);
    logic [10:0] fr;
    int n;
    fr = nine ? {1'b1, ninth, d, 1'b0} : {2'b11, d, 1'b0};
    n = nine ? 11 : 10;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_sys);
      if (p)
        port1_rxd <= fr[i];
      else
        port0_rxd <= fr[i];
      repeat (per - 1) @(posedge clk_sys);
    end
  endtask

  // Samples on the falling clock edge so the flop output has settled
  task automatic recv(input bit p, input bit nine, input int per,
    output logic [7:0] d, output logic ninth, output logic stop,
    output logic ok);
    logic [9:0] fr;
    int t;
    t = 0;
    fr = '0;
    do
    begin
      @(negedge clk_sys);
      t++;
    end while ((p ? port1_txd : port0_txd) !== 1'b0 && t < 200);
    repeat (per / 2) @(negedge clk_sys);
    ok = ((p ? port1_txd : port0_txd) === 1'b0) && (t < 200);
    for (int i = 0; i < (nine ? 10 : 9); i++)
    begin
      repeat (per) @(negedge clk_sys);
      fr[i] = p ? port1_txd : port0_txd;
    end
    d = fr[7:0];
    ninth = nine ? fr[8] : 1'b0;
    stop = nine ? fr[9] : fr[8];
  endtask
endmodule

// ==== tb/dual_uart_serial_control_tb.sv ====
`timescale 1ns/1ps
`include "dusc_regs.svh"
module dual_uart_serial_control_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rdata;
  logic irq;
  logic port0_txd;
  logic port0_rxd;
  logic port1_txd;
  logic port1_rxd;
  int bad_count = 0;
  int checked = 0;
  logic [7:0] d;
  logic nb;
  logic sb;
  logic ok;
  logic [7:0] pw [4] = '{8'h00, 8'h80, 8'h80, 8'h00};
  logic [7:0] cw [4] = '{8'h98, 8'h90, 8'hD8, 8'h58};
  logic [7:0] dw [4] = '{8'hA5, 8'h3C, 8'h96, 8'h69};
  int pr [4] = '{64, 32, 8, 16};

  always #2.5 clk_sys = ~clk_sys;

  dusc_serial_ctrl u_dut (.clk_sys(clk_sys), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq),
    .port0_txd(port0_txd), .port0_rxd(port0_rxd), .port1_txd(port1_txd),
    .port1_rxd(port1_rxd));

  dusc_peer u_peer (.clk_sys(clk_sys), .port0_txd(port0_txd),
    .port1_txd(port1_txd), .port0_rxd(port0_rxd), .port1_rxd(port1_rxd));

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] seen,
    input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp,
    input string name);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    chk(name, rdata, exp);
  endtask

  initial
  begin
    #200000;
    bad_count++;
    end_of_test();
  end

  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk(`DUSC_OFF_CTRL0, 8'h00, "ctrl0 reset");
    rd_chk(`DUSC_OFF_CTRL1, 8'h00, "ctrl1 reset");
    rd_chk(`DUSC_OFF_PWR, 8'h00, "pwr reset");
    rd_chk(`DUSC_OFF_ISTAT, 8'h00, "istat reset");
    rd_chk(8'h0F, 8'h00, "unmapped");
    // Mode 00 must keep the line idle even after a data write
    wr(`DUSC_OFF_TXD0, 8'h55);
    ok = 1'b1;
    repeat (200)
    begin
      @(negedge clk_sys);
      if (port0_txd !== 1'b1)
        ok = 1'b0;
    end
    chk("p0 idle in mode 00", {7'h00, ok}, 8'h01);
    wr(`DUSC_OFF_DIV0, 8'h00);
    wr(`DUSC_OFF_IMASK, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      wr(`DUSC_OFF_PWR, pw[i]);
      wr(`DUSC_OFF_CTRL0, cw[i]);
      wr(`DUSC_OFF_ISTAT, 8'h0F);
      wr(`DUSC_OFF_TXD0, dw[i]);
      u_peer.recv(1'b0, cw[i][7], pr[i], d, nb, sb, ok);
      chk("p0 start bit", {7'h00, ok}, 8'h01);
      chk("p0 data", d, dw[i]);
      chk("p0 ninth", {7'h00, nb}, {7'h00, cw[i][7] & cw[i][3]});
      chk("p0 stop", {7'h00, sb}, 8'h01);
      repeat (pr[i] + 6) @(posedge clk_sys);
      rd_chk(`DUSC_OFF_CTRL0, cw[i] | 8'h02, "p0 tx done");
      chk("irq set", {7'h00, irq}, 8'h01);
    end
    wr(`DUSC_OFF_IMASK, 8'h00);
    @(negedge clk_sys);
    chk("irq masked", {7'h00, irq}, 8'h00);
    wr(`DUSC_OFF_IMASK, 8'h01);
    wr(`DUSC_OFF_ISTAT, 8'h01);
    @(negedge clk_sys);
    chk("irq cleared", {7'h00, irq}, 8'h00);
    rd_chk(`DUSC_OFF_CTRL0, 8'h5A, "p0 tx done sticky");
    // Mode 1 receive: ninth receive bit takes the stop bit
    wr(`DUSC_OFF_PWR, 8'h00);
    wr(`DUSC_OFF_CTRL0, 8'h50);
    u_peer.send(1'b0, 8'h5A, 1'b0, 1'b0, 16);
    repeat (8) @(posedge clk_sys);
    rd_chk(`DUSC_OFF_RXD0, 8'h5A, "p0 rx data");
    rd_chk(`DUSC_OFF_CTRL0, 8'h55, "p0 rx flags");
    rd_chk(`DUSC_OFF_ISTAT, 8'h02, "p0 rx status");
    wr(`DUSC_OFF_CTRL0, 8'h40);
    u_peer.send(1'b0, 8'h11, 1'b0, 1'b0, 16);
    repeat (8) @(posedge clk_sys);
    rd_chk(`DUSC_OFF_RXD0, 8'h5A, "p0 rx disabled data");
    rd_chk(`DUSC_OFF_CTRL0, 8'h40, "p0 rx disabled flag");
    // Port 1 mode A, then mode B
    wr(`DUSC_OFF_DIV1, 8'h00);
    wr(`DUSC_OFF_CTRL1, 8'h18);
    wr(`DUSC_OFF_TXD1, 8'h81);
    u_peer.recv(1'b1, 1'b1, 16, d, nb, sb, ok);
    chk("p1 start bit", {7'h00, ok}, 8'h01);
    chk("p1 data", d, 8'h81);
    chk("p1 ninth", {7'h00, nb}, 8'h01);
    chk("p1 stop", {7'h00, sb}, 8'h01);
    repeat (22) @(posedge clk_sys);
    u_peer.send(1'b1, 8'h42, 1'b1, 1'b1, 16);
    repeat (8) @(posedge clk_sys);
    rd_chk(`DUSC_OFF_RXD1, 8'h42, "p1 rx data");
    rd_chk(`DUSC_OFF_CTRL1, 8'h1F, "p1 mode A flags");
    // Handshake feature on: a 9-bit frame with ninth bit 0 is dropped
    wr(`DUSC_OFF_CTRL1, 8'h30);
    u_peer.send(1'b1, 8'h77, 1'b0, 1'b1, 16);
    repeat (8) @(posedge clk_sys);
    rd_chk(`DUSC_OFF_RXD1, 8'h42, "p1 mproc drop data");
    rd_chk(`DUSC_OFF_CTRL1, 8'h30, "p1 mproc drop flags");
    wr(`DUSC_OFF_CTRL1, 8'h90);
    u_peer.send(1'b1, 8'h33, 1'b0, 1'b0, 16);
    repeat (8) @(posedge clk_sys);
    rd_chk(`DUSC_OFF_RXD1, 8'h33, "p1 mode B data");
    rd_chk(`DUSC_OFF_CTRL1, 8'h95, "p1 mode B flags");
    wr(`DUSC_OFF_TXD1, 8'hC3);
    rd_chk(`DUSC_OFF_LSTAT, 8'h02, "p1 busy");
    u_peer.recv(1'b1, 1'b0, 16, d, nb, sb, ok);
    chk("p1 B data", d, 8'hC3);
    chk("p1 B stop", {7'h00, sb}, 8'h01);
    end_of_test();
  end
endmodule
